/* verilog/irq_index_cfg.svh */
// Operation
// - After the mask op executes, process and time interrupts go unserviced.
// - The unmask op cancels masking and restores interrupt service.
// - Mask and unmask execute whatever the logic result bit holds.
// - Mask and unmask leave the logic result bit and condition codes alone.
// - Requests raised while masked stay pending and are served after unmask.
// - The indexed prefix spans two program words, whatever the result bit.
// - The next statement takes its parameter from the named index word.
// - Indexed bit ops: bit address in high byte, byte address in low byte.
// - Indexing: scan, set, timer, count, load, jump, shift, inc/dec, call.
// - Indexed input AND-scan, marker index, byte above 127: scan outputs.
`ifndef IRQ_INDEX_CFG_SVH
`define IRQ_INDEX_CFG_SVH

// ****************************************
// Register map (word indexes, compared with wb_adr_i[7:2])
// ****************************************
`define REG_CTRL 6'h00
`define REG_STATUS 6'h01
`define REG_SUBST_COUNT 6'h02
`define REG_LAST_PARAM 6'h03

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_IRQ_EN_LSB 0
`define CTRL_RESET 2'h3
`define STAT_MASKED_BIT 0
`define STAT_PEND_LSB 1
`define STAT_ARMED_BIT 3
`define STAT_FAULT_BIT 4

// ****************************************
// Decode constants
// ****************************************
`define REDIRECT_BYTE_LIMIT 8'h7f
`define SUB_AND_SCAN 2'h0

`endif

/* verilog/irq_index_pkg.sv */
package irq_index_pkg;

  typedef enum logic [3:0] {
    OP_OTHER = 4'h0,
    OP_MASK = 4'h1,
    OP_UNMASK = 4'h2,
    OP_INDEX = 4'h3,
    OP_BOOL = 4'h4,
    OP_SETRST = 4'h5,
    OP_TIMER = 4'h6,
    OP_COUNTER = 4'h7,
    OP_LOADXFER = 4'h8,
    OP_JUMP = 4'h9,
    OP_SHIFT = 4'ha,
    OP_DECINC = 4'hb,
    OP_BLOCKCALL = 4'hc
  } op_e;

  typedef enum logic [2:0] {
    AREA_NONE = 3'h0,
    AREA_INPUT = 3'h1,
    AREA_OUTPUT = 3'h2,
    AREA_MARKER = 3'h3,
    AREA_STORAGE = 3'h4,
    AREA_TIMER = 3'h5,
    AREA_COUNTER = 3'h6,
    AREA_BLOCK = 3'h7
  } area_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ARMED = 2'b10
  } state_e;

  // Param layout: [15:8] bit address, [7:0] byte address or word value
  typedef struct packed {
    op_e op;
    logic [1:0] sub;
    area_e area;
    logic [15:0] param;
    logic lrb_write;
    logic cc_write;
  } stmt_s;

  typedef struct packed {
    stmt_s stmt;
    logic indexed;
  } exec_s;

endpackage : irq_index_pkg

/* verilog/index_mapper.sv */
`timescale 1ns/1ps
`include "irq_index_cfg.svh"

module index_mapper (
  // Statement after the prefix
  input irq_index_pkg::stmt_s stmt_i,
  // Prefix source and fetched index word
  input irq_index_pkg::area_e src_i,
  input wire logic [15:0] idx_word_i,
  // Mapped result
  output irq_index_pkg::stmt_s stmt_o,
  output logic permitted_o,
  output logic fault_o
);
  import irq_index_pkg::*;

  logic bit_op;

  always_comb begin
    stmt_o = stmt_i;
    bit_op = (stmt_i.op == OP_BOOL || stmt_i.op == OP_SETRST) &&
             (stmt_i.area == AREA_INPUT || stmt_i.area == AREA_OUTPUT ||
              stmt_i.area == AREA_MARKER);
    unique case (stmt_i.op)
      OP_BOOL, OP_SETRST, OP_TIMER, OP_COUNTER, OP_LOADXFER, OP_JUMP,
      OP_SHIFT, OP_DECINC, OP_BLOCKCALL: permitted_o = 1'b1;
      default: permitted_o = 1'b0;
    endcase
    // High byte carries the bit, low byte the byte address
    stmt_o.param = idx_word_i;
    if (stmt_i.op == OP_BOOL && stmt_i.sub == `SUB_AND_SCAN &&
        stmt_i.area == AREA_INPUT && src_i == AREA_MARKER &&
        idx_word_i[7:0] > `REDIRECT_BYTE_LIMIT) begin
      stmt_o.area = AREA_OUTPUT;
    end
    // Misuse by the program is flagged, never silently fixed
    fault_o = !permitted_o || (stmt_i.param != 16'h0000) ||
              (!bit_op && idx_word_i[15:8] != 8'h00);
  end

endmodule : index_mapper

/* verilog/irq_index_unit.sv */
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "irq_index_cfg.svh"

module irq_index_unit #(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Decoded statement stream
  input wire logic stmt_valid_i,
  input irq_index_pkg::stmt_s stmt_i,
  input wire logic [15:0] idx_word_i,
  input wire logic logic_result_bit_i,
  // Executed statement
  output logic exec_valid_o,
  output irq_index_pkg::exec_s exec_o,
  // Interrupts: bit 0 process, bit 1 time
  input wire logic [1:0] irq_req_i,
  output logic [1:0] irq_service_o,
  output logic irq_masked_o
);
  import irq_index_pkg::*;

  localparam int NUM_IRQ = 2;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count_w
    $error("COUNT_W must lie in 1..32");
  end

  function automatic logic hits(input logic [7:0] adr,
                                input logic [5:0] idx);
    hits = (adr[7:2] == idx);
  endfunction : hits

  // ****************************************
  // Registers and state
  // ****************************************
  logic [1:0] ctrl_reg;
  logic masked_reg;
  logic [1:0] pend_reg;
  logic fault_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [15:0] last_param_reg;
  state_e state_reg;
  area_e src_reg;
  logic [15:0] idx_word_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic exec_valid_reg;
  exec_s exec_reg;
  logic [1:0] service_reg;

  logic req;
  logic wr;
  logic mask_now;
  logic unmask_now;
  logic index_now;
  logic subst_now;
  logic block_irq;
  logic [1:0] service_next;
  logic [1:0] set_pend;
  stmt_s mapped;
  logic permitted;
  logic map_fault;
  logic fault_clr;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i && wb_sel_i[0];
  // Mask ops ignore the logic result bit on purpose
  assign mask_now = stmt_valid_i && stmt_i.op == OP_MASK;
  assign unmask_now = stmt_valid_i && stmt_i.op == OP_UNMASK;
  assign index_now = stmt_valid_i && stmt_i.op == OP_INDEX &&
                     state_reg == ST_IDLE;
  assign subst_now = stmt_valid_i && state_reg == ST_ARMED && permitted;
  assign fault_clr = wr && hits(wb_adr_i, `REG_STATUS) &&
                     wb_dat_i[`STAT_FAULT_BIT];

  index_mapper u_mapper (
    .stmt_i(stmt_i),
    .src_i(src_reg),
    .idx_word_i(idx_word_reg),
    .stmt_o(mapped),
    .permitted_o(permitted),
    .fault_o(map_fault)
  );

  // ****************************************
  // Wishbone slave
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req) begin
      rdata_reg <= 32'h0000_0000;
      if (hits(wb_adr_i, `REG_CTRL)) begin
        rdata_reg[1:0] <= ctrl_reg;
      end else if (hits(wb_adr_i, `REG_STATUS)) begin
        rdata_reg[`STAT_MASKED_BIT] <= masked_reg;
        rdata_reg[`STAT_PEND_LSB +: 2] <= pend_reg;
        rdata_reg[`STAT_ARMED_BIT] <= (state_reg == ST_ARMED);
        rdata_reg[`STAT_FAULT_BIT] <= fault_reg;
      end else if (hits(wb_adr_i, `REG_SUBST_COUNT)) begin
        rdata_reg[COUNT_W-1:0] <= count_reg;
      end else if (hits(wb_adr_i, `REG_LAST_PARAM)) begin
        rdata_reg[15:0] <= last_param_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr && hits(wb_adr_i, `REG_CTRL)) begin
      ctrl_reg <= wb_dat_i[`CTRL_IRQ_EN_LSB +: 2];
    end
  end

  // ****************************************
  // Interrupt masking
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      masked_reg <= 1'b0;
    end else if (mask_now) begin
      masked_reg <= 1'b1;
    end else if (unmask_now) begin
      masked_reg <= 1'b0;
    end
  end

  // Service is held off already in the cycle the mask op arrives
  assign block_irq = masked_reg || mask_now;

  always_comb begin
    service_next = 2'b00;
    if (!block_irq) begin
      if (pend_reg[0]) begin
        service_next[0] = 1'b1;
      end else if (pend_reg[1]) begin
        service_next[1] = 1'b1;
      end
    end
  end

  // New request wins over the clear caused by servicing
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_pend
    assign set_pend[i] = irq_req_i[i] && ctrl_reg[i];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pend_reg[i] <= 1'b0;
      end else if (set_pend[i]) begin
        pend_reg[i] <= 1'b1;
      end else if (service_next[i]) begin
        pend_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      service_reg <= 2'b00;
    end else begin
      service_reg <= service_next;
    end
  end

  // ****************************************
  // Indexed execution sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (index_now) begin
            state_reg <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (stmt_valid_i) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_reg <= AREA_NONE;
      idx_word_reg <= 16'h0000;
    end else if (index_now) begin
      src_reg <= stmt_i.area;
      idx_word_reg <= idx_word_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exec_valid_reg <= 1'b0;
      exec_reg <= '0;
    end else begin
      exec_valid_reg <= stmt_valid_i && !index_now;
      exec_reg.stmt <= stmt_i;
      exec_reg.indexed <= 1'b0;
      if (mask_now || unmask_now) begin
        exec_reg.stmt.lrb_write <= 1'b0;
        exec_reg.stmt.cc_write <= 1'b0;
      end else if (subst_now) begin
        exec_reg.stmt <= mapped;
        exec_reg.indexed <= 1'b1;
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else if (stmt_valid_i && state_reg == ST_ARMED && map_fault) begin
      fault_reg <= 1'b1;
    end else if (fault_clr) begin
      fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
      last_param_reg <= 16'h0000;
    end else if (subst_now) begin
      count_reg <= count_reg + 1'b1;
      last_param_reg <= mapped.param;
    end else if (wr && hits(wb_adr_i, `REG_SUBST_COUNT)) begin
      count_reg <= '0;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign exec_valid_o = exec_valid_reg;
  assign exec_o = exec_reg;
  assign irq_service_o = service_reg;
  assign irq_masked_o = masked_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_mask_stops;
    mask_now |=> irq_masked_o && irq_service_o == 2'b00;
  endproperty
  a_mask_stops: assert property (p_mask_stops)
    else $error("service seen after mask op");

  property p_masked_quiet;
    masked_reg |=> irq_service_o == 2'b00;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("service while masked");

  property p_unmask_clears;
    unmask_now && !mask_now |=> !irq_masked_o;
  endproperty
  a_unmask_clears: assert property (p_unmask_clears)
    else $error("unmask did not clear mask");

  property p_mask_no_lrb;
    mask_now && !logic_result_bit_i |=> irq_masked_o;
  endproperty
  a_mask_no_lrb: assert property (p_mask_no_lrb)
    else $error("mask op depended on logic result bit");

  property p_mask_keeps_flags;
    (mask_now || unmask_now) |=> exec_valid_o &&
      !exec_o.stmt.lrb_write && !exec_o.stmt.cc_write;
  endproperty
  a_mask_keeps_flags: assert property (p_mask_keeps_flags)
    else $error("mask op touched result or condition codes");

  property p_held_then_served;
    masked_reg && pend_reg[0] && unmask_now ##1 !mask_now
      |=> irq_service_o[0];
  endproperty
  a_held_then_served: assert property (p_held_then_served)
    else $error("held process request not serviced after unmask");

  property p_index_arms;
    index_now && !logic_result_bit_i |=> state_reg == ST_ARMED &&
      !exec_valid_o;
  endproperty
  a_index_arms: assert property (p_index_arms)
    else $error("prefix did not arm or was emitted");

  property p_subst_param;
    subst_now |=> exec_o.indexed && exec_o.stmt.param == $past(idx_word_reg);
  endproperty
  a_subst_param: assert property (p_subst_param)
    else $error("parameter not taken from index word");

  property p_redirect;
    subst_now && stmt_i.op == OP_BOOL && stmt_i.sub == `SUB_AND_SCAN &&
      stmt_i.area == AREA_INPUT && src_reg == AREA_MARKER &&
      idx_word_reg[7:0] > `REDIRECT_BYTE_LIMIT |=>
      exec_o.stmt.area == AREA_OUTPUT;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("input scan not redirected to outputs");

  property p_one_shot;
    state_reg == ST_ARMED && stmt_valid_i |=> state_reg == ST_IDLE;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("substitution reached a second statement");

  property p_fault_set;
    stmt_valid_i && state_reg == ST_ARMED && map_fault |=> fault_reg;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("misused prefix not flagged");

  c_masked_service: cover property (masked_reg && set_pend[0] ##[1:20]
    irq_service_o[0]);
  c_subst: cover property (subst_now ##1 exec_o.indexed);
  c_redirect: cover property (subst_now && mapped.area != stmt_i.area);
  c_fault: cover property ($rose(fault_reg));

endmodule : irq_index_unit

/* test/tb.sv */
`timescale 1ns/1ps
`include "irq_index_cfg.svh"

module tb;
  import irq_index_pkg::*;

  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic stmt_valid_i = 1'b0;
  stmt_s stmt_i = '0;
  logic [15:0] idx_word_i = 16'h0;
  logic logic_result_bit_i = 1'b0;
  logic exec_valid_o;
  exec_s exec_o;
  logic [1:0] irq_req_i = 2'h0;
  logic [1:0] irq_service_o;
  logic irq_masked_o;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic [3:0] h;
  op_e op_k;
  stmt_s alt;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  irq_index_unit DUT (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .stmt_valid_i(stmt_valid_i), .stmt_i(stmt_i),
    .idx_word_i(idx_word_i), .logic_result_bit_i(logic_result_bit_i),
    .exec_valid_o(exec_valid_o), .exec_o(exec_o),
    .irq_req_i(irq_req_i), .irq_service_o(irq_service_o),
    .irq_masked_o(irq_masked_o)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Holds the request until ack is sampled, for at most 20 cycles
  task wb(input logic we, input logic [5:0] r, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {r, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) chk(32'h0, 32'h1, "no bus ack");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task rd(input logic [5:0] r, input logic [31:0] exp);
    wb(1'b0, r, 32'h0);
    chk(q, exp, "register read");
  endtask : rd

  function automatic stmt_s mk(input op_e o, input area_e a,
                               input logic [15:0] p);
    mk = '{op: o, sub: 2'h0, area: a, param: p, lrb_write: 1'b1,
           cc_write: 1'b1};
  endfunction : mk

  task run(input stmt_s s, input logic [15:0] idx, input logic v,
           input area_e a, input logic [15:0] p, input logic ix);
    @(posedge clk_i);
    stmt_valid_i <= 1'b1;
    stmt_i <= s;
    idx_word_i <= idx;
    @(posedge clk_i);
    stmt_valid_i <= 1'b0;
    #1;
    chk(exec_valid_o, v, "exec valid");
    if (v) begin
      chk(exec_o.stmt.op, s.op, "exec op");
      chk(exec_o.stmt.area, a, "exec area");
      chk(exec_o.stmt.param, p, "exec param");
      chk(exec_o.indexed, ix, "exec indexed");
      chk(exec_o.stmt.sub, s.sub, "exec sub");
    end
  endtask : run

  task pre(input area_e a, input logic [15:0] idx);
    run(mk(OP_INDEX, a, 16'h0), idx, 1'b0, AREA_NONE, 16'h0, 1'b0);
  endtask : pre

  task ex(input op_e o, input area_e a, input logic [15:0] p,
          input area_e ea, input logic [15:0] ep, input logic ix);
    run(mk(o, a, p), 16'h0, 1'b1, ea, ep, ix);
  endtask : ex

  task pulse_irq(input logic [1:0] r);
    @(posedge clk_i);
    irq_req_i <= r;
    @(posedge clk_i);
    irq_req_i <= 2'h0;
  endtask : pulse_irq

  // Shifts in every non-idle service pattern, so order is visible
  task svc(input int n);
    h = 4'h0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (irq_service_o !== 2'h0) h = {h[1:0], irq_service_o};
    end
  endtask : svc

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (4000) @(posedge clk_i);
    miscompares++;
    finish_test;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`REG_CTRL, 32'h3);
    rd(`REG_STATUS, 32'h0);
    rd(`REG_SUBST_COUNT, 32'h0);
    wb(1'b1, 6'h10, 32'hff);
    rd(6'h10, 32'h0);
    // Only the enabled source may be serviced
    wb(1'b1, `REG_CTRL, 32'h1);
    rd(`REG_CTRL, 32'h1);
    pulse_irq(2'h3);
    svc(5);
    chk(h, 4'h1, "enabled service only");
    wb(1'b1, `REG_CTRL, 32'h3);
    // Mask with the result bit low, unmask with it high
    ex(OP_MASK, AREA_NONE, 16'h0, AREA_NONE, 16'h0, 1'b0);
    chk(irq_masked_o, 1'b1, "masked after mask");
    chk(exec_o.stmt.lrb_write, 1'b0, "mask lrb write");
    chk(exec_o.stmt.cc_write, 1'b0, "mask cc write");
    pulse_irq(2'h3);
    svc(6);
    chk(h, 4'h0, "service while masked");
    rd(`REG_STATUS, 32'h7);
    logic_result_bit_i <= 1'b1;
    ex(OP_UNMASK, AREA_NONE, 16'h0, AREA_NONE, 16'h0, 1'b0);
    chk(irq_masked_o, 1'b0, "unmasked");
    chk(exec_o.stmt.lrb_write, 1'b0, "unmask lrb write");
    chk(exec_o.stmt.cc_write, 1'b0, "unmask cc write");
    svc(6);
    chk(h, 4'h6, "held requests serviced");
    rd(`REG_STATUS, 32'h0);
    // Prefix plus one statement
    pre(AREA_MARKER, 16'h0108);
    rd(`REG_STATUS, 32'h8);
    ex(OP_BOOL, AREA_INPUT, 16'h0, AREA_INPUT, 16'h0108, 1'b1);
    ex(OP_BOOL, AREA_INPUT, 16'h0203, AREA_INPUT, 16'h0203, 1'b0);
    // Byte address boundary of the output redirect
    pre(AREA_MARKER, 16'h0080);
    ex(OP_BOOL, AREA_INPUT, 16'h0, AREA_OUTPUT, 16'h0080, 1'b1);
    pre(AREA_MARKER, 16'h007f);
    ex(OP_BOOL, AREA_INPUT, 16'h0, AREA_INPUT, 16'h007f, 1'b1);
    pre(AREA_STORAGE, 16'h0090);
    ex(OP_BOOL, AREA_INPUT, 16'h0, AREA_INPUT, 16'h0090, 1'b1);
    // Only the AND scan is redirected
    alt = mk(OP_BOOL, AREA_INPUT, 16'h0);
    alt.sub = 2'h1;
    pre(AREA_MARKER, 16'h0080);
    run(alt, 16'h0, 1'b1, AREA_INPUT, 16'h0080, 1'b1);
    logic_result_bit_i <= 1'b0;
    // Every permitted operation group
    for (int k = 4; k <= 12; k++) begin
      op_k = op_e'(4'(k));
      pre(AREA_STORAGE, 16'h0005);
      ex(op_k, AREA_STORAGE, 16'h0, AREA_STORAGE, 16'h0005, 1'b1);
    end
    rd(`REG_SUBST_COUNT, 32'he);
    rd(`REG_LAST_PARAM, 32'h5);
    rd(`REG_STATUS, 32'h0);
    wb(1'b1, `REG_SUBST_COUNT, 32'h0);
    rd(`REG_SUBST_COUNT, 32'h0);
    // Operation outside the permitted list is passed through and flagged
    pre(AREA_STORAGE, 16'h0005);
    ex(OP_OTHER, AREA_STORAGE, 16'h0007, AREA_STORAGE, 16'h0007, 1'b0);
    rd(`REG_STATUS, 32'h10);
    wb(1'b1, `REG_STATUS, 32'h10);
    rd(`REG_STATUS, 32'h0);
    // A second prefix while armed is a plain, flagged statement
    pre(AREA_MARKER, 16'h0108);
    ex(OP_INDEX, AREA_STORAGE, 16'h0, AREA_STORAGE, 16'h0, 1'b0);
    ex(OP_BOOL, AREA_INPUT, 16'h0001, AREA_INPUT, 16'h0001, 1'b0);
    rd(`REG_SUBST_COUNT, 32'h0);
    rd(`REG_STATUS, 32'h10);
    wb(1'b1, `REG_STATUS, 32'h10);
    rd(`REG_STATUS, 32'h0);
    // Nonzero parameter field after the prefix is flagged
    pre(AREA_STORAGE, 16'h0005);
    ex(OP_JUMP, AREA_STORAGE, 16'h0002, AREA_STORAGE, 16'h0005, 1'b1);
    rd(`REG_STATUS, 32'h10);
    wb(1'b1, `REG_STATUS, 32'h10);
    rd(`REG_STATUS, 32'h0);
    // Non-bit operation with a nonzero index high byte
    pre(AREA_STORAGE, 16'h0105);
    ex(OP_TIMER, AREA_TIMER, 16'h0, AREA_TIMER, 16'h0105, 1'b1);
    rd(`REG_STATUS, 32'h10);
    finish_test;
  end

endmodule : tb
